// File: cvs_defines.svh
// Timing counts and field positions for the character video serializer.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CVS_DEFINES_SVH
`define CVS_DEFINES_SVH

`define CVS_DOT_W        4
`define CVS_DOT_RELOAD   4'h6
`define CVS_DOT_TOP      4'hf
`define CVS_ROW_W        10
`define CVS_CHAR_W       8
`define CVS_CHAR_MSB     7
`define CVS_SWEEPS       4'he
`define CVS_GFX_BAND     3'h4
`define CVS_ADDR_W       10
`define CVS_SYM_W        7
`define CVS_HDIV_W       8
`define CVS_HDIV_TOP     8'h74

`endif

// File: cvs_pkg.sv
// Types shared by the character video serializer modules.
// Assumes cvs_defines.svh is on the include path.
package cvs_pkg;
	typedef logic [9:0] cvs_row_t;
	typedef logic [7:0] cvs_char_t;
	typedef enum logic [1:0] {
		CVS_VIS  = 2'b00,
		CVS_BLNK = 2'b01
	} cvs_hstate_t;
endpackage : cvs_pkg

// File: cvs_gen_if.sv
// Carries the latched character and row selection between the top and the generator mux.
// Assumes both ends run from the same clock.
`timescale 1ns/100ps
`default_nettype none
interface cvs_gen_if;
	cvs_pkg::cvs_char_t code;
	logic [3:0]         sweep;
	logic [1:0]         band;
	logic               gfx_sel_n;
	cvs_pkg::cvs_row_t  rom_row;
	cvs_pkg::cvs_row_t  row;
	modport top (output code, output sweep, output band, output gfx_sel_n, output rom_row, input row);
	modport gen (input code, input sweep, input band, input gfx_sel_n, input rom_row, output row);
endinterface : cvs_gen_if
`default_nettype wire

// File: cvs_gen_mux.sv
// Chooses between character ROM rows and block graphics rows for the shift register.
// Assumes the ROM row arrives already looked up for the current code and sweep.
`timescale 1ns/100ps
`default_nettype none
module cvs_gen_mux (
	cvs_gen_if.gen g
);
	cvs_pkg::cvs_row_t gfx_row;
	logic [1:0]        pair;

	// Each 2-bit slice of the low code bits lights the left or right half in one band of five sweeps.
	always_comb begin
		pair = 2'h0;
		unique case (g.band)
			2'h0: pair = g.code[1:0];
			2'h1: pair = g.code[3:2];
			default: pair = g.code[5:4];
		endcase
		gfx_row = {{5{pair[1]}}, {5{pair[0]}}};
	end

	// A low select picks the graphics row.
	assign g.row = g.gfx_sel_n ? g.rom_row : gfx_row;
endmodule : cvs_gen_mux
`default_nettype wire

// File: cvs_top.sv
// Character video datapath: dot counter, character latch, symbol counter and dot shifter.
// Assumes display RAM data and ROM rows come from logic on ref_clk_i; blanking is a pin input.
`timescale 1ns/100ps
`default_nettype none
`include "cvs_defines.svh"
module cvs_top (
	// Clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	// Blanking pin
	input  wire logic                    hblank_i,
	// Display memory
	input  wire logic [7:0]              ram_data_i,
	output logic [`CVS_ADDR_W-1:0]       ram_addr_o,
	// Character ROM
	input  wire logic [9:0]              rom_row_i,
	output logic [7:0]                   rom_code_o,
	output logic [3:0]                   rom_sweep_o,
	// Video and timing
	output logic                         video_o,
	output logic                         eoc_o,
	output logic                         load_n_o,
	output logic                         shift_clk_n_o,
	output logic                         hsync_o,
	output logic [`CVS_SYM_W-1:0]        symbol_o
);
	cvs_gen_if gif ();

	logic                   blank_s1_ff, blank_s2_ff;
	logic [`CVS_DOT_W-1:0]  dot_ff, nxt_dot;
	logic                   eoc_ff, nxt_eoc;
	logic                   load_n_ff, nxt_load_n;
	logic                   sclk_n_ff, nxt_sclk_n;
	cvs_pkg::cvs_char_t     char_ff, nxt_char;
	logic [`CVS_ADDR_W-1:0] addr_ff, nxt_addr;
	logic [`CVS_SYM_W-1:0]  sym_ff, nxt_sym;
	cvs_pkg::cvs_row_t      shift_ff, nxt_shift;
	logic                   video_ff, nxt_video;
	logic [`CVS_HDIV_W-1:0] hdiv_ff, nxt_hdiv;
	logic                   hsync_ff, nxt_hsync;
	logic [3:0]             sweep_ff, nxt_sweep;
	logic [2:0]             band_cnt_ff, nxt_band_cnt;
	logic [1:0]             band_ff, nxt_band;
	cvs_pkg::cvs_hstate_t   hst_ff, nxt_hst;
	logic                   dot_en;
	logic                   carry;

	// The blanking pin comes from a monostable on another timebase, so it is synchronised first.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blank_s1_ff <= 1'b0;
			blank_s2_ff <= 1'b0;
		end else begin
			blank_s1_ff <= hblank_i;
			blank_s2_ff <= blank_s1_ff;
		end
	end

	always_comb begin
		nxt_hst = blank_s2_ff ? cvs_pkg::CVS_BLNK : cvs_pkg::CVS_VIS;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hst_ff <= cvs_pkg::CVS_VIS;
		end else begin
			hst_ff <= nxt_hst;
		end
	end

	// The dot period is one clock; blanking, once through the synchroniser and hst_ff, stops every dot-rate event together.
	assign dot_en = (hst_ff == cvs_pkg::CVS_VIS);
	assign carry  = dot_en && (dot_ff == `CVS_DOT_TOP);

	always_comb begin
		nxt_dot    = dot_ff;
		nxt_eoc    = carry;
		nxt_load_n = !carry;
		nxt_sclk_n = !dot_en;
		nxt_char   = char_ff;
		nxt_addr   = addr_ff;
		nxt_sym    = sym_ff;
		nxt_shift  = shift_ff;
		nxt_video  = video_ff;
		if (dot_en) begin
			nxt_dot   = carry ? `CVS_DOT_RELOAD : dot_ff + 4'h1;
			nxt_video = shift_ff[9];
			nxt_shift = {shift_ff[8:0], 1'b0};
		end
		if (carry) begin
			// Latch inverts the top bit so a set memory bit reads as a low graphics select.
			nxt_char  = {~ram_data_i[`CVS_CHAR_MSB], ram_data_i[6:0]};
			nxt_addr  = addr_ff + 10'h001;
			nxt_sym   = sym_ff + 7'h01;
			nxt_shift = gif.row;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dot_ff    <= `CVS_DOT_RELOAD;
			eoc_ff    <= 1'b0;
			load_n_ff <= 1'b1;
			sclk_n_ff <= 1'b1;
			char_ff   <= 8'h80;
			addr_ff   <= 10'h000;
			sym_ff    <= 7'h00;
			shift_ff  <= 10'h000;
			video_ff  <= 1'b0;
		end else begin
			dot_ff    <= nxt_dot;
			eoc_ff    <= nxt_eoc;
			load_n_ff <= nxt_load_n;
			sclk_n_ff <= nxt_sclk_n;
			char_ff   <= nxt_char;
			addr_ff   <= nxt_addr;
			sym_ff    <= nxt_sym;
			shift_ff  <= nxt_shift;
			video_ff  <= nxt_video;
		end
	end

	// Sweep timing runs from the system clock alone, so it keeps going through blanking.
	always_comb begin
		nxt_hdiv     = (hdiv_ff == `CVS_HDIV_TOP) ? 8'h00 : hdiv_ff + 8'h01;
		nxt_hsync    = (hdiv_ff == `CVS_HDIV_TOP);
		nxt_sweep    = sweep_ff;
		nxt_band_cnt = band_cnt_ff;
		nxt_band     = band_ff;
		if (hdiv_ff == `CVS_HDIV_TOP) begin
			if (sweep_ff == `CVS_SWEEPS) begin
				nxt_sweep    = 4'h0;
				nxt_band_cnt = 3'h0;
				nxt_band     = 2'h0;
			end else begin
				nxt_sweep = sweep_ff + 4'h1;
				if (band_cnt_ff == `CVS_GFX_BAND) begin
					nxt_band_cnt = 3'h0;
					nxt_band     = band_ff + 2'h1;
				end else begin
					nxt_band_cnt = band_cnt_ff + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hdiv_ff     <= 8'h00;
			hsync_ff    <= 1'b0;
			sweep_ff    <= 4'h0;
			band_cnt_ff <= 3'h0;
			band_ff     <= 2'h0;
		end else begin
			hdiv_ff     <= nxt_hdiv;
			hsync_ff    <= nxt_hsync;
			sweep_ff    <= nxt_sweep;
			band_cnt_ff <= nxt_band_cnt;
			band_ff     <= nxt_band;
		end
	end

	assign gif.code      = char_ff;
	assign gif.sweep     = sweep_ff;
	assign gif.band      = band_ff;
	assign gif.gfx_sel_n = char_ff[`CVS_CHAR_MSB];
	assign gif.rom_row   = rom_row_i;

	cvs_gen_mux u_mux (
		.g (gif.gen)
	);

	assign ram_addr_o    = addr_ff;
	assign rom_code_o    = char_ff;
	assign rom_sweep_o   = sweep_ff;
	assign video_o       = video_ff;
	assign eoc_o         = eoc_ff;
	assign load_n_o      = load_n_ff;
	assign shift_clk_n_o = sclk_n_ff;
	assign hsync_o       = hsync_ff;
	assign symbol_o      = sym_ff;
endmodule : cvs_top
`default_nettype wire

// File: cvs_checker.sv
// Port assertions for the character video serializer.
// Assumes binding to cvs_top on one clock.
`timescale 1ns/100ps
`default_nettype none
module cvs_checker (
	// Clock and reset
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	// Watched ports
	input wire logic       hblank_i,
	input wire logic [7:0] ram_data_i,
	input wire logic [9:0] ram_addr_o,
	input wire logic [7:0] rom_code_o,
	input wire logic [3:0] rom_sweep_o,
	input wire logic       video_o,
	input wire logic       eoc_o,
	input wire logic       load_n_o,
	input wire logic       shift_clk_n_o,
	input wire logic       hsync_o,
	input wire logic [6:0] symbol_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_quiet; !eoc_o [*8]; endsequence
	property p_strobe; eoc_o == !load_n_o; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe mismatch");
	property p_space; eoc_o |=> s_quiet; endproperty
	a_space: assert property (p_space) else $error("eoc too close");
	property p_addr; eoc_o |-> ram_addr_o == $past(ram_addr_o) + 10'h1; endproperty
	a_addr: assert property (p_addr) else $error("address step");
	property p_sym; eoc_o |-> symbol_o == $past(symbol_o) + 7'h1; endproperty
	a_sym: assert property (p_sym) else $error("symbol step");
	property p_hold; !eoc_o |-> $stable(ram_addr_o) && $stable(symbol_o) && $stable(rom_code_o); endproperty
	a_hold: assert property (p_hold) else $error("latch moved");
	property p_code; eoc_o |-> rom_code_o == {~$past(ram_data_i[7]), $past(ram_data_i[6:0])}; endproperty
	a_code: assert property (p_code) else $error("code latch");
	property p_blank; hblank_i [*6] |-> shift_clk_n_o && !eoc_o && $stable(video_o); endproperty
	a_blank: assert property (p_blank) else $error("dots in blank");
	property p_shift; !hblank_i [*6] |-> !shift_clk_n_o; endproperty
	a_shift: assert property (p_shift) else $error("shift clock idle");
	property p_hsync; hsync_o |-> ##117 hsync_o; endproperty
	a_hsync: assert property (p_hsync) else $error("hsync period");
	property p_sweep; $changed(rom_sweep_o) |-> rom_sweep_o == ($past(rom_sweep_o) == 4'he ? 4'h0 : $past(rom_sweep_o) + 4'h1); endproperty
	a_sweep: assert property (p_sweep) else $error("sweep step");
endmodule : cvs_checker
bind cvs_top cvs_checker u_chk (.*);
`default_nettype wire

// File: cvs_monitor.sv
// Monitor model gathering the ten dots after each character load.
// Assumes no blanking inside a judged character.
`timescale 1ns/100ps
`default_nettype none
module cvs_monitor (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	// Dot stream
	input  wire logic       video_i,
	input  wire logic       eoc_i,
	// Gathered character, first dot in bit 9
	output logic [9:0]      word_o
);
	logic [3:0] cnt_ff;
	logic [9:0] sr_ff;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 4'h0;
			sr_ff  <= 10'h0;
			word_o <= 10'h0;
		end else begin
			if (cnt_ff != 4'h0) sr_ff <= {sr_ff[8:0], video_i};
			if (cnt_ff == 4'h1) word_o <= {sr_ff[8:0], video_i};
			cnt_ff <= eoc_i ? 4'ha : (cnt_ff == 4'h0 ? 4'h0 : cnt_ff - 4'h1);
		end
	end
endmodule : cvs_monitor
`default_nettype wire

// File: cvs_top_bench.sv
// Self-checking bench for the serializer with a dot monitor.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module cvs_top_bench;
	logic        ref_clk_i, rst_n_i, hblank_i, video_o, eoc_o, load_n_o, shift_clk_n_o, hsync_o;
	logic [7:0]  ram_data_i, rom_code_o;
	logic [9:0]  rom_row_i, ram_addr_o, word;
	logic [3:0]  rom_sweep_o;
	logic [6:0]  symbol_o;
	int          error_cnt, check_count, i, n;
	// Rows of {memory byte, dots}; graphics codes light the same halves in every band.
	logic [17:0] rows [7] = '{18'h0d6b5, 18'h00280, 18'h3ffff, 18'h2abe0, 18'h2541f, 18'h20000, 18'h1feff};
	// Graphics byte 8'hb9 lights a different half pattern in each band of five sweeps.
	logic [9:0]  bands [3] = '{10'h01f, 10'h3e0, 10'h3ff};
	cvs_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hblank_i(hblank_i), .ram_data_i(ram_data_i),
		.ram_addr_o(ram_addr_o), .rom_row_i(rom_row_i), .rom_code_o(rom_code_o), .rom_sweep_o(rom_sweep_o),
		.video_o(video_o), .eoc_o(eoc_o), .load_n_o(load_n_o), .shift_clk_n_o(shift_clk_n_o),
		.hsync_o(hsync_o), .symbol_o(symbol_o));
	cvs_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .video_i(video_o), .eoc_i(eoc_o), .word_o(word));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// The ROM stand-in ignores the sweep so expected dots do not depend on row timing.
	initial rom_row_i = 10'h0;
	always @(negedge ref_clk_i) rom_row_i <= {2'b10, rom_code_o};
	task automatic chk(input string nm, input logic [29:0] exp, input logic [29:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic do_reset;
		rst_n_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		chk("reset", {8'h80, 17'h0, 5'h0c}, {rom_code_o, ram_addr_o, symbol_o, eoc_o, load_n_o, shift_clk_n_o, hsync_o, video_o});
		rst_n_i = 1'b1;
	endtask : do_reset
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#500000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		error_cnt = 0;
		check_count = 0;
		hblank_i = 1'b0;
		ram_data_i = 8'h0;
		do_reset();
		n = 0;
		while (eoc_o !== 1'b1 && n < 40) begin
			@(negedge ref_clk_i);
			n++;
		end
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (eoc_o !== 1'b1 && n < 40);
		chk("eoc spacing", 30'h00a, 30'(n));
		for (i = 0; i < 7; i++) begin
			ram_data_i = rows[i][17:10];
			repeat (40) @(negedge ref_clk_i);
			chk("dot word", {20'h0, rows[i][9:0]}, {20'h0, word});
		end
		// Sample well inside each band so a row loaded near a band edge cannot be judged.
		ram_data_i = 8'hb9;
		for (i = 0; i < 3; i++) begin
			n = 0;
			while (rom_sweep_o !== 4'(5 * i + 2) && n < 2000) begin
				@(negedge ref_clk_i);
				n++;
			end
			repeat (40) @(negedge ref_clk_i);
			chk("band word", {20'h0, bands[i]}, {20'h0, word});
		end
		hblank_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
		n = 0;
		repeat (40) begin
			@(negedge ref_clk_i);
			if (eoc_o !== 1'b0 || shift_clk_n_o !== 1'b1) n++;
		end
		chk("blank activity", 30'h0, 30'(n));
		hblank_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		chk("shift clock", 30'h0, {29'h0, shift_clk_n_o});
		do_reset();
		give_verdict();
	end
endmodule : cvs_top_bench
`default_nettype wire
